// >>> core/charger_pkg.sv
// Shared constants for the charger control-pin block: register map,
// field positions, reset values and timing counts.
// Assumes a 100 MHz pclk and a 32-bit APB register bus.
package charger_pkg;

    // ========================================================
    // Clock and timing
    localparam int CLK_MHZ = 100;
    localparam int FAULT_PULSE_US = 128;
    // Whole cycles in the fault pulse, at least one
    localparam int FAULT_PULSE_CYCLES =
        (FAULT_PULSE_US * CLK_MHZ < 1) ? 1 : FAULT_PULSE_US * CLK_MHZ;

    // ========================================================
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_CONTROL = 8'h00;
    localparam logic [7:0] IDX_STATUS = 8'h01;
    localparam logic [7:0] IDX_INT_STATUS = 8'h02;
    localparam logic [7:0] IDX_INT_MASK = 8'h03;
    localparam logic [7:0] IDX_SAFETY_LIMIT = 8'h06;

    // ========================================================
    // Control register fields
    localparam int CTL_EN_STAT = 0;
    localparam int CTL_PIN_BOOST_EN = 1;
    localparam int CTL_SW_BOOST = 2;
    localparam int CTL_MODE_32S = 3;
    localparam logic [3:0] CONTROL_RESET = 4'h1;

    // ========================================================
    // Status register fields (read only)
    localparam int ST_CHARGING = 0;
    localparam int ST_PULSE = 1;
    localparam int ST_BOOST = 2;
    localparam int ST_ILIM_500 = 3;
    localparam int ST_CHG_EN = 4;
    localparam int ST_LOCKED = 5;
    localparam int ST_SL_RESET_PIN = 6;

    // ========================================================
    // Interrupt status and mask fields
    localparam int INT_FAULT = 0;
    localparam int INT_CHG_DONE = 1;
    localparam int INT_CD_CHANGE = 2;
    localparam int INT_BITS = 3;
    localparam logic [2:0] INT_MASK_RESET = 3'h0;

    // ========================================================
    // Safety-limit register default
    localparam logic [7:0] SAFETY_LIMIT_RESET = 8'h00;

endpackage

// >>> core/pin_sync.sv
// Three-stage synchroniser for asynchronous pin inputs.
// A new level is accepted once the second and third stages agree.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pins and synchronised levels
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level
);

    initial begin
        if (WIDTH < 1) $error("pin_sync: WIDTH must be at least 1");
    end

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] q;
    } sync_t;

    sync_t st;
    sync_t next_st;

    // ========================================================
    // Stage one feeds only stage two; agreement filters glitches
    always_comb begin
        next_st = st;
        next_st.s1 = pin_in;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        for (int i = 0; i < WIDTH; i++) begin
            if (st.s2[i] == st.s3[i]) next_st.q[i] = st.s3[i];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st <= '0;
        else st <= next_st;
    end

    assign level = st.q;

endmodule
`default_nettype wire

// >>> core/pulse_timer.sv
// One-shot pulse generator: a start pulse opens a window of
// CYCLES clock cycles. Starts while busy are ignored.
`timescale 1ns/1ps
`default_nettype none
module pulse_timer #(
    parameter int CYCLES = 12800
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Trigger and window
    input wire logic start,
    output logic busy
);

    localparam int CW = $clog2(CYCLES + 1);

    initial begin
        if (CYCLES < 1) $error("pulse_timer: CYCLES must be at least 1");
    end

    typedef struct packed {
        logic [CW-1:0] count;
        logic busy;
    } timer_t;

    timer_t st;
    timer_t next_st;

    // ========================================================
    // Counter sized from the cycle count so the width is exact
    always_comb begin
        next_st = st;
        if (st.busy) begin
            if (st.count == CW'(1)) next_st.busy = 1'b0; // R17
            next_st.count = st.count - CW'(1); // R17
        end else if (start) begin
            next_st.busy = 1'b1;
            next_st.count = CW'(CYCLES); // R17
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) st <= '0;
        else st <= next_st;
    end

    assign busy = st.busy;

endmodule
`default_nettype wire

// >>> core/charger_control_pins.sv
// Control-pin logic of a single-cell charger: status pin with fault
// pulse, charge-disable pin, dual-role boost / current-limit pin, safety-limit reset pin and
// an APB register file with a sticky interrupt.
// Assumes charger core signals on pclk; pins arrive asynchronously.
//
// What this block does
// R1 - Status pin low while charging
// R2 - Status pin released otherwise, except pulse
// R3 - Fault gives one 128 us pulse
// R4 - Status enable bit cleared silences pin
// R5 - Charge-disable low permits charging
// R6 - Charge-disable high stops charge, supply Hi-Z
// R7 - 15 min mode: disable resets timer
// R8 - 32 s mode: disable leaves timer
// R9 - Boost pin active and enabled forces boost
// R10 - Pin beats software boost; bit disables pin
// R11 - After reset pin selects current limit
// R12 - Pin high 500 mA, low 100 mA
// R13 - Reset pin low holds safety limits default
// R14 - Reset pin low ignores safety writes
// R15 - Reset pin high allows unlocked safety writes
// R16 - Write elsewhere locks safety limits
// R17 - Fault pulse timed by sized counter
`timescale 1ns/1ps
`default_nettype none
module charger_control_pins #(
    parameter int FAULT_PULSE_CYCLES = charger_pkg::FAULT_PULSE_CYCLES,
    parameter bit BOOST_VARIANT = 1'b1,
    parameter bit BOOST_ACTIVE_HIGH = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device pins
    input wire logic charge_disable_in,
    input wire logic boost_request_in,
    input wire logic safety_limit_reset_in,
    output logic stat_out,
    output logic stat_oe,
    // Charger core
    input wire logic charge_in_progress,
    input wire logic fault_event,
    output logic charge_enable,
    output logic vbus_hiz,
    output logic timer15_reset,
    output logic boost_mode,
    output logic ilim_500,
    output logic [7:0] safety_limit,
    // Interrupt
    output logic irq
);

    initial begin
        if (FAULT_PULSE_CYCLES < 1)
            $error("charger_control_pins: pulse length below one cycle");
    end

    // ========================================================
    // State of the block
    typedef struct packed {
        logic [7:0] safety_limit;
        logic locked;
        logic [3:0] control;
        logic [2:0] int_status;
        logic [2:0] int_mask;
        logic [31:0] rdata;
        logic charging_d;
        logic cd_d;
        logic charge_enable;
        logic vbus_hiz;
        logic timer15_reset;
        logic boost_mode;
        logic ilim_500;
        logic stat_oe;
    } state_t;

    state_t st;
    state_t next_st;

    // ========================================================
    // Pin synchronisers
    logic [2:0] pin_level;
    logic cd_sync;
    logic boost_pin_sync;
    logic safety_limit_reset_in_sync;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin_in({safety_limit_reset_in, boost_request_in,
                 charge_disable_in}),
        .level(pin_level)
    );

    assign cd_sync = pin_level[0];
    assign boost_pin_sync = pin_level[1];
    // The boost variant has no safety-limit reset pin: limits writable
    assign safety_limit_reset_in_sync = BOOST_VARIANT ? 1'b1 : pin_level[2];

    // ========================================================
    // Fault pulse timer
    logic pulse_start;
    logic pulse_busy;

    // Faults seen while the pin is disabled start no pulse
    assign pulse_start =
        fault_event && st.control[charger_pkg::CTL_EN_STAT]; // R4

    pulse_timer #(
        .CYCLES(FAULT_PULSE_CYCLES)
    ) u_pulse_timer (
        .pclk(pclk),
        .presetn(presetn),
        .start(pulse_start), // R3
        .busy(pulse_busy)
    );

    // ========================================================
    // APB decode
    logic setup_phase;
    logic access_phase;
    logic wr_access;
    logic [5:0] word_idx;
    logic addr_ok;
    logic hit_control;
    logic hit_int_status;
    logic hit_int_mask;
    logic hit_safety;
    logic mapped;

    assign setup_phase = psel && !penable;
    assign access_phase = psel && penable;
    assign wr_access = access_phase && pwrite;
    assign word_idx = paddr[7:2];
    assign addr_ok = (paddr[1:0] == 2'h0);
    assign hit_control =
        addr_ok && (word_idx == charger_pkg::IDX_CONTROL[5:0]);
    assign hit_int_status =
        addr_ok && (word_idx == charger_pkg::IDX_INT_STATUS[5:0]);
    assign hit_int_mask =
        addr_ok && (word_idx == charger_pkg::IDX_INT_MASK[5:0]);
    assign hit_safety =
        addr_ok && (word_idx == charger_pkg::IDX_SAFETY_LIMIT[5:0]);
    // Status is readable only; a write to it is answered with an error
    assign mapped = hit_control || hit_int_status || hit_int_mask
        || hit_safety || (addr_ok && !pwrite
        && word_idx == charger_pkg::IDX_STATUS[5:0]);

    // Read data is latched in setup, so no wait state is needed
    assign pready = access_phase;
    assign pslverr = access_phase && !mapped;

    // ========================================================
    // Status word as software sees it
    logic [31:0] status_word;

    always_comb begin
        status_word = 32'h0;
        status_word[charger_pkg::ST_CHARGING] = st.charging_d;
        status_word[charger_pkg::ST_PULSE] = pulse_busy;
        status_word[charger_pkg::ST_BOOST] = st.boost_mode;
        status_word[charger_pkg::ST_ILIM_500] = st.ilim_500;
        status_word[charger_pkg::ST_CHG_EN] = st.charge_enable;
        status_word[charger_pkg::ST_LOCKED] = st.locked;
        status_word[charger_pkg::ST_SL_RESET_PIN] = safety_limit_reset_in_sync;
    end

    // ========================================================
    // Pin-derived controls
    logic boost_pin_active;
    logic pin_boost_en;
    logic [2:0] int_events;

    assign boost_pin_active = (boost_pin_sync == BOOST_ACTIVE_HIGH);
    assign pin_boost_en =
        BOOST_VARIANT && st.control[charger_pkg::CTL_PIN_BOOST_EN];

    // Fault, end of a charge cycle, and any change on charge-disable
    always_comb begin
        int_events = 3'h0;
        int_events[charger_pkg::INT_FAULT] = fault_event;
        int_events[charger_pkg::INT_CHG_DONE] =
            st.charging_d && !charge_in_progress;
        int_events[charger_pkg::INT_CD_CHANGE] = cd_sync != st.cd_d;
    end

    // ========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        next_st.charging_d = charge_in_progress;
        next_st.cd_d = cd_sync;

        // Read data captured in setup, held through the access phase
        if (setup_phase && !pwrite) begin
            next_st.rdata = 32'h0;
            if (hit_control) next_st.rdata[3:0] = st.control;
            else if (hit_int_status)
                next_st.rdata[2:0] = st.int_status;
            else if (hit_int_mask) next_st.rdata[2:0] = st.int_mask;
            else if (hit_safety) next_st.rdata[7:0] = st.safety_limit;
            else if (addr_ok
                     && word_idx == charger_pkg::IDX_STATUS[5:0])
                next_st.rdata = status_word;
        end

        // Register writes take effect at the access edge
        if (wr_access && hit_control) next_st.control = pwdata[3:0];
        if (wr_access && hit_int_mask) next_st.int_mask = pwdata[2:0];

        // Safety limits: writable only with reset pin high, unlocked
        if (wr_access && hit_safety && safety_limit_reset_in_sync && !st.locked)
            next_st.safety_limit = pwdata[7:0]; // R15
        // Any write reaching another register seals the limits
        if (wr_access && mapped && !hit_safety)
            next_st.locked = 1'b1; // R16
        // Reset pin low: defaults forced, lock cleared and every limit write ignored
        if (!safety_limit_reset_in_sync) begin
            next_st.safety_limit = charger_pkg::SAFETY_LIMIT_RESET; // R13
            next_st.locked = 1'b0; // R14
        end

        // Sticky interrupts: write one clears, a new event wins
        if (wr_access && hit_int_status)
            next_st.int_status = st.int_status & ~pwdata[2:0];
        next_st.int_status = next_st.int_status | int_events;

        // Charge-disable pin
        next_st.charge_enable = !cd_sync; // R5
        next_st.vbus_hiz = cd_sync; // R6
        // Only the 15 minute timer is cleared; the 32 s one runs on
        next_st.timer15_reset =
            cd_sync && !st.control[charger_pkg::CTL_MODE_32S]; // R7 R8

        // Dual-role pin: boost request or current-limit selector
        if (pin_boost_en) begin
            next_st.boost_mode = boost_pin_active; // R9 R10
            next_st.ilim_500 = st.ilim_500;
        end else begin
            next_st.boost_mode = BOOST_VARIANT
                && st.control[charger_pkg::CTL_SW_BOOST];
            // High selects 500 mA, low 100 mA; fixed 500 mA otherwise
            next_st.ilim_500 =
                BOOST_VARIANT ? boost_pin_sync : 1'b1; // R11 R12
        end

        // Status pin: enable bit first, then pulse, then charging, otherwise released
        if (!st.control[charger_pkg::CTL_EN_STAT])
            next_st.stat_oe = 1'b0; // R4
        else if (pulse_busy)
            next_st.stat_oe = 1'b1; // R3
        else
            next_st.stat_oe = charge_in_progress && !cd_sync; // R1 R2
    end

    // ========================================================
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st <= '0;
            st.control <= charger_pkg::CONTROL_RESET;
            st.int_mask <= charger_pkg::INT_MASK_RESET;
            st.safety_limit <= charger_pkg::SAFETY_LIMIT_RESET;
            st.ilim_500 <= 1'b0;
        end else begin
            st <= next_st;
        end
    end

    // ========================================================
    // Outputs
    assign prdata = st.rdata;
    // Open drain: the pin only ever pulls low
    assign stat_out = 1'b0;
    assign stat_oe = st.stat_oe;
    assign charge_enable = st.charge_enable;
    assign vbus_hiz = st.vbus_hiz;
    assign timer15_reset = st.timer15_reset;
    assign boost_mode = st.boost_mode;
    assign ilim_500 = st.ilim_500;
    assign safety_limit = st.safety_limit;
    assign irq = |(st.int_status & st.int_mask);

endmodule
`default_nettype wire

// >>> bench/charger_control_pins_chk.sv
// Concurrent checks on the charger control-pin block's ports.
// Assumes the bench drives pins and core inputs just after pclk edges.
`timescale 1ns/1ps
`default_nettype none
module charger_control_pins_chk #(
    parameter int FAULT_PULSE_CYCLES = 8,
    parameter bit BOOST_VARIANT = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    // Pins and charger core
    input wire logic charge_disable_in,
    input wire logic safety_limit_reset_in,
    input wire logic charge_in_progress,
    input wire logic stat_out,
    input wire logic stat_oe,
    input wire logic charge_enable,
    input wire logic vbus_hiz,
    input wire logic timer15_reset,
    input wire logic [7:0] safety_limit
);
    // ====================================================
    // Helper state
    logic acc;
    logic sl_wr_q;
    logic locked_q;
    logic chg_q;
    int run_q;
    assign acc = psel && penable && pwrite;
    // Lock tracking and length of a status low not caused by charging
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sl_wr_q <= 1'b0;
            locked_q <= 1'b0;
            chg_q <= 1'b0;
            run_q <= 0;
        end else begin
            sl_wr_q <= acc && paddr == 8'h18;
            chg_q <= charge_in_progress;
            if (acc && paddr inside {8'h00, 8'h08, 8'h0c})
                locked_q <= 1'b1;
            // The reset pin of the non-boost variant unseals the limits
            if (!BOOST_VARIANT && !safety_limit_reset_in)
                locked_q <= 1'b0;
            // A charge-driven low must not count as a fault pulse
            if (!stat_oe || chg_q)
                run_q <= 0;
            else
                run_q <= run_q + 1;
        end
    end
    // ====================================================
    // Assertions
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    AST_CD_HIZ: assert property (charge_disable_in [*6] |=> vbus_hiz)
        else $error("supply not released after disable pin");
    AST_CD_RUN: assert property (
        !charge_disable_in [*6] |=> charge_enable)
        else $error("charging not permitted with disable pin low");
    AST_HIZ_STOP: assert property (vbus_hiz |-> !charge_enable)
        else $error("charge enabled while supply released");
    AST_T15: assert property (timer15_reset |-> vbus_hiz)
        else $error("timer reset without charge disable");
    AST_OPEN_DRAIN: assert property (stat_oe |-> !stat_out)
        else $error("status pin driven high");
    AST_PULSE_MAX: assert property (run_q <= FAULT_PULSE_CYCLES)
        else $error("fault pulse too long");
    AST_PULSE_LEN: assert property ($fell(stat_oe) |->
        run_q == 0 || run_q == FAULT_PULSE_CYCLES)
        else $error("fault pulse of wrong length");
    AST_SL_WRITE: assert property ($changed(safety_limit) |->
        sl_wr_q || (!BOOST_VARIANT && !safety_limit_reset_in))
        else $error("safety limit changed without a write");
    AST_LOCK: assert property (locked_q |-> $stable(safety_limit))
        else $error("safety limit changed after lock");
    COV_HIZ: cover property (vbus_hiz && timer15_reset);
    COV_PULSE: cover property ($fell(stat_oe) && run_q == FAULT_PULSE_CYCLES);
    COV_LOCKED_WR: cover property (locked_q && sl_wr_q);
endmodule

bind charger_control_pins charger_control_pins_chk #(
    .FAULT_PULSE_CYCLES(FAULT_PULSE_CYCLES),
    .BOOST_VARIANT(BOOST_VARIANT)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .charge_disable_in(charge_disable_in),
    .safety_limit_reset_in(safety_limit_reset_in),
    .charge_in_progress(charge_in_progress), .stat_out(stat_out),
    .stat_oe(stat_oe), .charge_enable(charge_enable), .vbus_hiz(vbus_hiz),
    .timer15_reset(timer15_reset), .safety_limit(safety_limit)
);
`default_nettype wire

// >>> bench/charger_pin_host.sv
// Host-side model of the charger's control pins and status LED line.
// Assumes requests from the bench change just after pclk edges.
`timescale 1ns/1ps
`default_nettype none
module charger_pin_host (
    // Clock
    input wire logic pclk,
    // Requests from the bench
    input wire logic cd_req,
    input wire logic boost_req,
    input wire logic slr_req,
    // Device pins
    input wire logic stat_out,
    input wire logic stat_oe,
    output logic charge_disable_in,
    output logic boost_request_in,
    output logic safety_limit_reset_in,
    // Observed status line
    output logic stat_level,
    output int low_len
);
    int cnt;
    // Pull-up holds the line high unless the device sinks it
    assign stat_level = stat_oe ? stat_out : 1'b1;
    // Pins start at rest so the device never sees an unknown level
    initial begin
        charge_disable_in = 1'b0;
        boost_request_in = 1'b0;
        safety_limit_reset_in = 1'b1;
        low_len = 0;
        cnt = 0;
    end
    // Pins follow requests one edge later; low stretches are measured
    always @(posedge pclk) begin
        charge_disable_in <= cd_req;
        boost_request_in <= boost_req;
        safety_limit_reset_in <= slr_req;
        if (stat_level === 1'b0)
            cnt <= cnt + 1;
        else if (cnt != 0) begin
            low_len <= cnt;
            cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// >>> bench/charger_control_pins_tb.sv
// Self-checking bench for the charger control-pin block.
// Assumes a 100 MHz pclk and a short fault pulse parameter.
`timescale 1ns/1ps
`default_nettype none
module charger_control_pins_tb;
    localparam int PULSE = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr, safety_limit, sl_limit;
    logic [31:0] pwdata, prdata;
    logic cd_pin, boost_pin, slr_pin, stat_out, stat_oe, stat_level;
    logic charge_in_progress, fault_event, charge_enable, vbus_hiz;
    logic timer15_reset, boost_mode, ilim_500, irq;
    logic cd_req, boost_req, slr_req;
    int low_len, bad_count, checks_done;

    charger_control_pins #(.FAULT_PULSE_CYCLES(PULSE)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .charge_disable_in(cd_pin),
        .boost_request_in(boost_pin), .safety_limit_reset_in(slr_pin),
        .stat_out(stat_out), .stat_oe(stat_oe),
        .charge_in_progress(charge_in_progress), .fault_event(fault_event),
        .charge_enable(charge_enable), .vbus_hiz(vbus_hiz),
        .timer15_reset(timer15_reset), .boost_mode(boost_mode),
        .ilim_500(ilim_500), .safety_limit(safety_limit), .irq(irq)
    );
    charger_pin_host host (
        .pclk(pclk), .cd_req(cd_req), .boost_req(boost_req),
        .slr_req(slr_req), .stat_out(stat_out), .stat_oe(stat_oe),
        .charge_disable_in(cd_pin), .boost_request_in(boost_pin),
        .safety_limit_reset_in(slr_pin), .stat_level(stat_level),
        .low_len(low_len)
    );
    // Variant with the safety-limit reset pin; only its limits are watched
    charger_control_pins #(.FAULT_PULSE_CYCLES(PULSE), .BOOST_VARIANT(1'b0))
    DUT_SL (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .charge_disable_in(cd_pin),
        .boost_request_in(boost_pin), .safety_limit_reset_in(slr_pin),
        .stat_out(), .stat_oe(), .charge_in_progress(charge_in_progress),
        .fault_event(fault_event), .charge_enable(), .vbus_hiz(),
        .timer15_reset(), .boost_mode(), .ilim_500(),
        .safety_limit(sl_limit), .irq()
    );
    // ====================================================
    // Clock and helpers
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
             input logic [31:0] e, input logic er);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Waits as long as the slave does; the watchdog ends a hang
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        if (!w)
            chk(prdata, e);
        chk(32'(pslverr), 32'(er));
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task fault;
        fault_event <= 1'b1;
        @(posedge pclk);
        fault_event <= 1'b0;
    endtask
    task summarize;
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // ====================================================
    // Hang guard, far beyond the length of the sequence
    initial begin
        repeat (4000) @(posedge pclk);
        bad_count++;
        summarize();
    end
    // ====================================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, fault_event} = 5'h0;
        {charge_in_progress, cd_req, boost_req} = 3'h0;
        slr_req = 1'b1;
        paddr = 8'h00;
        pwdata = 32'h0;
        bad_count = 0;
        checks_done = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        tick(8);
        // Reset values, unmapped and read-only places
        apb(1'b0, 8'h00, 32'h0, 32'h1, 1'b0);
        apb(1'b0, 8'h0c, 32'h0, 32'h0, 1'b0);
        apb(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 8'h04, 32'h0, 32'h0, 1'b1);
        // Safety limits writable, then locked by another write
        apb(1'b0, 8'h18, 32'h0, 32'h0, 1'b0);
        apb(1'b1, 8'h18, 32'h5a, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h5a, 1'b0);
        apb(1'b1, 8'h0c, 32'h1, 32'h0, 1'b0);
        apb(1'b1, 8'h18, 32'ha5, 32'h0, 1'b0);
        apb(1'b0, 8'h18, 32'h0, 32'h5a, 1'b0);
        chk(32'(safety_limit), 32'h5a);
        // Charge disable in both timer modes
        cd_req <= 1'b1;
        tick(10);
        chk(32'(vbus_hiz), 32'h1);
        chk(32'(charge_enable), 32'h0);
        chk(32'(timer15_reset), 32'h1);
        cd_req <= 1'b0;
        tick(10);
        chk(32'(charge_enable), 32'h1);
        apb(1'b1, 8'h00, 32'h9, 32'h0, 1'b0);
        cd_req <= 1'b1;
        tick(10);
        chk(32'(timer15_reset), 32'h0);
        chk(32'(vbus_hiz), 32'h1);
        cd_req <= 1'b0;
        apb(1'b1, 8'h00, 32'h1, 32'h0, 1'b0);
        tick(10);
        // Status line while charging and after
        charge_in_progress <= 1'b1;
        tick(4);
        chk(32'(stat_level), 32'h0);
        charge_in_progress <= 1'b0;
        tick(4);
        chk(32'(stat_level), 32'h1);
        // Fault pulse, sticky status, mask and clear
        apb(1'b1, 8'h08, 32'h7, 32'h0, 1'b0);
        chk(32'(irq), 32'h0);
        fault();
        tick(20);
        chk(32'(low_len), 32'(PULSE));
        chk(32'(irq), 32'h1);
        apb(1'b0, 8'h08, 32'h0, 32'h1, 1'b0);
        apb(1'b1, 8'h08, 32'h1, 32'h0, 1'b0);
        tick(1);
        chk(32'(irq), 32'h0);
        // Status enable cleared: line stays released
        apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        charge_in_progress <= 1'b1;
        fault();
        for (int i = 0; i < 12; i++) begin
            @(posedge pclk);
            chk(32'(stat_level), 32'h1);
        end
        charge_in_progress <= 1'b0;
        // Boost pin as current-limit select, then as boost request
        boost_req <= 1'b1;
        tick(10);
        chk(32'(ilim_500), 32'h1);
        chk(32'(boost_mode), 32'h0);
        boost_req <= 1'b0;
        tick(10);
        chk(32'(ilim_500), 32'h0);
        apb(1'b1, 8'h00, 32'h2, 32'h0, 1'b0);
        boost_req <= 1'b1;
        tick(10);
        chk(32'(boost_mode), 32'h1);
        apb(1'b1, 8'h00, 32'h0, 32'h0, 1'b0);
        tick(4);
        chk(32'(boost_mode), 32'h0);
        apb(1'b1, 8'h00, 32'h4, 32'h0, 1'b0);
        tick(4);
        chk(32'(boost_mode), 32'h1);
        apb(1'b0, 8'h04, 32'h0, 32'h7c, 1'b0);
        // Reset pin on the second variant: defaults, ignored writes
        slr_req <= 1'b0;
        tick(8);
        chk(32'(sl_limit), 32'h0);
        apb(1'b1, 8'h18, 32'h33, 32'h0, 1'b0);
        tick(1);
        chk(32'(sl_limit), 32'h0);
        slr_req <= 1'b1;
        tick(8);
        apb(1'b1, 8'h18, 32'h33, 32'h0, 1'b0);
        tick(1);
        chk(32'(sl_limit), 32'h33);
        chk(32'(safety_limit), 32'h5a);
        summarize();
    end
endmodule
`default_nettype wire
